// ==== core/redundant_temp_voting.v ====
// Redundant coolant temperature voting for four loops with a Wishbone register port.
// Assumes readings and flags are stable and synchronous to clock through the four loop cycles of a pass.
//
// Our own choices: the address map and the Wishbone interface to the registers.
`include "redundant_temp_voting_regs.vh"
`default_nettype none

module redundant_temp_voting #(
	parameter W = 16
) (
	// Clock and reset.
	input wire clock,
	input wire rst,
	// Wishbone slave.
	input wire wbCyc,
	input wire wbStb,
	input wire wbWe,
	input wire [7:0] wbAdr,
	input wire [3:0] wbSel,
	input wire [31:0] wbDatW,
	output reg [31:0] wbDatR,
	output reg wbAck,
	// Sensor inputs: per loop, cold 0..1 then hot 0..2, five slots per loop.
	input wire sampleStrobe,
	input wire [20*W-1:0] readings,
	input wire [19:0] inputBad,
	input wire [19:0] inputFlagB,
	input wire [19:0] inputLowScale,
	// Loop results.
	output reg [4*W-1:0] loopDelta,
	output reg [4*W-1:0] loopAverage,
	output reg [3:0] loopStatusA,
	output reg [3:0] sensorFailureStatus,
	output reg resultValid
);

	// Signed difference magnitude, one bit wider than the operands.
	function [W:0] absDiff;
		input [W-1:0] a;
		input [W-1:0] b;
		reg [W:0] d;
		begin
			d = {a[W-1], a} - {b[W-1], b};
			absDiff = d[W] ? (~d + {{W{1'b0}}, 1'b1}) : d;
		end
	endfunction

	// True when two values agree within the tolerance.
	function agree;
		input [W-1:0] a;
		input [W-1:0] b;
		input [W-1:0] tol;
		begin
			agree = absDiff(a, b) <= {1'b0, tol};
		end
	endfunction

	// Mean of two values, rounded toward minus infinity.
	function [W-1:0] mean2;
		input [W-1:0] a;
		input [W-1:0] b;
		reg [W:0] s;
		begin
			s = {a[W-1], a} + {b[W-1], b};
			mean2 = s[W:1];
		end
	endfunction

	// Byte-lane merge of a 16-bit register.
	function [15:0] laneWrite;
		input [15:0] old;
		input [15:0] data;
		input [1:0] sel;
		begin
			laneWrite[7:0] = sel[0] ? data[7:0] : old[7:0];
			laneWrite[15:8] = sel[1] ? data[15:8] : old[15:8];
		end
	endfunction

	// Configuration and result storage.
	reg [W-1:0] coldTol;
	reg [W-1:0] hotTol;
	reg [W-1:0] fullDt [0:3];
	reg [W-1:0] hotDetectorBias [0:11];
	reg [W-1:0] prevDelta [0:3];
	reg [W-1:0] deltaMem [0:3];
	reg [W-1:0] avgMem [0:3];
	reg [10:0] qualMem [0:3];
	reg busy;
	reg [1:0] loopIdx;
	integer k;
	integer j;
	integer m;

	// Bus decode.
	wire [5:0] wordIdx = wbAdr[7:2];
	wire busReq = wbCyc & wbStb & ~wbAck;
	wire busWr = busReq & wbWe;
	wire softStart = busWr & (wordIdx == `RTV_IDX_CTRL) & wbSel[0] & wbDatW[0];
	wire start = (sampleStrobe | softStart) & ~busy;
	wire [5:0] biasOff = wordIdx - `RTV_IDX_BIAS;
	wire [5:0] fullOff = wordIdx - `RTV_IDX_FULL_DT;

	// Slot selection for the loop under evaluation.
	wire [4:0] base = {loopIdx, 2'b00} + {3'b000, loopIdx};
	wire [3:0] biasBase = {loopIdx, 1'b0} + {2'b00, loopIdx};
	wire [W-1:0] cold0 = readings[base*W +: W];
	wire [W-1:0] cold1 = readings[(base+5'd1)*W +: W];
	wire cBad0 = inputBad[base];
	wire cBad1 = inputBad[base+5'd1];
	wire cDis0 = inputFlagB[base];
	wire cDis1 = inputFlagB[base+5'd1];

	// Cold group vote.
	reg [W-1:0] coldGroupValue;
	reg [1:0] coldQ;
	reg [1:0] coldPoor;
	always @* begin
		coldGroupValue = mean2(cold0, cold1);
		coldQ = `RTV_Q_BAD;
		coldPoor = 2'b00;
		if (cBad0 & cBad1) begin
			coldQ = `RTV_Q_BAD;
		end else if (cBad0 & cDis1) begin
			coldGroupValue = cold0;
		end else if (cBad1 & cDis0) begin
			coldGroupValue = cold1;
		end else if (cBad0 | cBad1) begin
			coldGroupValue = cBad0 ? cold1 : cold0;
			coldQ = `RTV_Q_POOR;
		end else if (cDis0 & cDis1) begin
			coldQ = `RTV_Q_BAD;
		end else if (cDis0 | cDis1) begin
			coldGroupValue = cDis0 ? cold1 : cold0;
			coldQ = `RTV_Q_POOR;
		end else if (agree(cold0, cold1, coldTol)) begin
			coldQ = `RTV_Q_GOOD;
		end else begin
			coldQ = `RTV_Q_BAD;
			coldPoor = 2'b11;
		end
	end

	// Power fraction from the previous sample of this loop.
	wire [W-1:0] lastDelta = prevDelta[loopIdx];
	wire [W-1:0] loopFullDt = fullDt[loopIdx];
	wire signed [W+`RTV_FRAC_BITS-1:0] fracNum = {lastDelta, {`RTV_FRAC_BITS{1'b0}}};
	wire signed [W+`RTV_FRAC_BITS-1:0] fracDen = {{`RTV_FRAC_BITS{loopFullDt[W-1]}}, loopFullDt};
	wire signed [W+`RTV_FRAC_BITS-1:0] fracQuot = fracNum / fracDen;
	wire [W-1:0] powerFrac = (loopFullDt == {W{1'b0}}) ? {W{1'b0}} : fracQuot[W-1:0];

	// Bias-corrected hot estimates.
	reg [W-1:0] est [0:2];
	reg [2:0] hGood;
	reg signed [2*W-1:0] prod;
	always @* begin
		prod = {2*W{1'b0}};
		for (j = 0; j < 3; j = j + 1) begin
			prod = $signed(powerFrac) * $signed(hotDetectorBias[biasBase + j[3:0]]);
			est[j] = readings[(base + 5'd2 + j[4:0])*W +: W]
				- prod[W+`RTV_FRAC_BITS-1:`RTV_FRAC_BITS];
			hGood[j] = ~inputBad[base + 5'd2 + j[4:0]] & ~inputFlagB[base + 5'd2 + j[4:0]];
		end
	end

	// Three-way mean and distances from it.
	wire [W+1:0] sum3 = {{2{est[0][W-1]}}, est[0]} + {{2{est[1][W-1]}}, est[1]}
		+ {{2{est[2][W-1]}}, est[2]};
	wire signed [W+1:0] three = {{W{1'b0}}, 2'h3};
	wire signed [W+1:0] quot3 = $signed(sum3) / three;
	wire [W-1:0] mean3 = quot3[W-1:0];
	wire [W:0] dev0 = absDiff(est[0], mean3);
	wire [W:0] dev1 = absDiff(est[1], mean3);
	wire [W:0] dev2 = absDiff(est[2], mean3);
	wire [W:0] hotLim = {1'b0, hotTol};

	// Hot group vote.
	reg [W-1:0] hotGroupValue;
	reg [1:0] hotQ;
	reg [2:0] hotPoor;
	reg [W-1:0] pa;
	reg [W-1:0] pb;
	reg [2:0] drop;
	always @* begin
		hotGroupValue = mean3;
		hotQ = `RTV_Q_BAD;
		hotPoor = 3'b000;
		pa = est[0];
		pb = est[1];
		drop = 3'b000;
		case (hGood)
			3'b000: begin
				hotQ = `RTV_Q_BAD;
			end
			3'b001, 3'b010, 3'b100: begin
				hotGroupValue = hGood[0] ? est[0] : (hGood[1] ? est[1] : est[2]);
				hotQ = `RTV_Q_BAD;
			end
			3'b011, 3'b101, 3'b110: begin
				pa = hGood[0] ? est[0] : est[1];
				pb = hGood[2] ? est[2] : est[1];
				hotGroupValue = mean2(pa, pb);
				if (agree(pa, pb, hotTol)) begin
					hotQ = `RTV_Q_GOOD;
				end else begin
					hotPoor = hGood;
				end
			end
			3'b111: begin
				if (dev0 <= hotLim && dev1 <= hotLim && dev2 <= hotLim) begin
					hotQ = `RTV_Q_GOOD;
				end else begin
					// Farthest goes; ties keep the lower index as the one dropped.
					if (dev0 >= dev1 && dev0 >= dev2) begin
						drop = 3'b001;
					end else if (dev1 >= dev2) begin
						drop = 3'b010;
					end else begin
						drop = 3'b100;
					end
					pa = drop[0] ? est[1] : est[0];
					pb = drop[2] ? est[1] : est[2];
					hotGroupValue = mean2(pa, pb);
					if (agree(pa, pb, hotTol)) begin
						hotQ = `RTV_Q_POOR;
						hotPoor = drop;
					end else begin
						hotPoor = 3'b111;
					end
				end
			end
			default: begin
				hotQ = `RTV_Q_BAD;
			end
		endcase
	end

	// Delta, average and alarm status of the loop.
	wire [W-1:0] deltaNow = hotGroupValue - coldGroupValue;
	wire [W:0] avgSum = {hotGroupValue[W-1], hotGroupValue} + {coldGroupValue[W-1], coldGroupValue};
	wire [W-1:0] avgNow = avgSum[W:1];
	wire coldAllLow = inputLowScale[base] & inputLowScale[base+5'd1];
	wire hotAllLow = inputLowScale[base+5'd2] & inputLowScale[base+5'd3]
		& inputLowScale[base+5'd4];
	wire failNow = ((coldQ == `RTV_Q_BAD) & ~coldAllLow) | ((hotQ == `RTV_Q_BAD) & ~hotAllLow);
	wire poorNow = ((coldQ == `RTV_Q_POOR) & ~coldAllLow) | ((hotQ == `RTV_Q_POOR) & ~hotAllLow);
	wire troubleNow = failNow | poorNow;
	wire [10:0] qualNow = {failNow, troubleNow, hotPoor, coldPoor, hotQ, coldQ};

	// Sequencer: one loop per cycle, four cycles per sample strobe.
	always @(posedge clock) begin
		resultValid <= 1'b0;
		if (rst) begin
			busy <= 1'b0;
			loopIdx <= 2'h0;
			loopDelta <= {4*W{1'b0}};
			loopAverage <= {4*W{1'b0}};
			loopStatusA <= 4'h0;
			sensorFailureStatus <= 4'h0;
			for (k = 0; k < 4; k = k + 1) begin
				prevDelta[k] <= {W{1'b0}};
				deltaMem[k] <= {W{1'b0}};
				avgMem[k] <= {W{1'b0}};
				qualMem[k] <= 11'h000;
			end
		end else if (start) begin
			busy <= 1'b1;
			loopIdx <= 2'h0;
		end else if (busy) begin
			prevDelta[loopIdx] <= deltaNow;
			deltaMem[loopIdx] <= deltaNow;
			avgMem[loopIdx] <= avgNow;
			qualMem[loopIdx] <= qualNow;
			loopDelta[loopIdx*W +: W] <= deltaNow;
			loopAverage[loopIdx*W +: W] <= avgNow;
			loopStatusA[loopIdx] <= troubleNow;
			sensorFailureStatus[loopIdx] <= failNow;
			loopIdx <= loopIdx + 2'h1;
			if (loopIdx == 2'h3) begin
				busy <= 1'b0;
				resultValid <= 1'b1;
			end
		end
	end

	// Register writes: tolerances, full-power deltas and detector biases.
	always @(posedge clock) begin
		if (rst) begin
			coldTol <= `RTV_COLD_TOL_RST;
			hotTol <= `RTV_HOT_TOL_RST;
			for (m = 0; m < 4; m = m + 1) begin
				fullDt[m] <= `RTV_FULL_DT_RST;
			end
			for (m = 0; m < 12; m = m + 1) begin
				hotDetectorBias[m] <= {W{1'b0}};
			end
		end else if (busWr) begin
			if (wordIdx == `RTV_IDX_COLD_TOL) begin
				coldTol <= laneWrite(coldTol, wbDatW[15:0], wbSel[1:0]);
			end
			if (wordIdx == `RTV_IDX_HOT_TOL) begin
				hotTol <= laneWrite(hotTol, wbDatW[15:0], wbSel[1:0]);
			end
			if (wordIdx >= `RTV_IDX_FULL_DT && wordIdx < `RTV_IDX_BIAS) begin
				fullDt[fullOff[1:0]] <= laneWrite(fullDt[fullOff[1:0]], wbDatW[15:0], wbSel[1:0]);
			end
			if (wordIdx >= `RTV_IDX_BIAS && wordIdx < `RTV_IDX_DELTA) begin
				hotDetectorBias[biasOff[3:0]] <= laneWrite(hotDetectorBias[biasOff[3:0]],
					wbDatW[15:0], wbSel[1:0]);
			end
		end
	end

	// Bus answer: one-cycle registered ack, unmapped words read as zero.
	always @(posedge clock) begin
		if (rst) begin
			wbAck <= 1'b0;
			wbDatR <= 32'h00000000;
		end else begin
			wbAck <= busReq;
			wbDatR <= 32'h00000000;
			if (busReq & ~wbWe) begin
				if (wordIdx == `RTV_IDX_STATUS) begin
					wbDatR <= {20'h00000, sensorFailureStatus, loopStatusA, 3'b000, busy};
				end else if (wordIdx == `RTV_IDX_COLD_TOL) begin
					wbDatR <= {16'h0000, coldTol};
				end else if (wordIdx == `RTV_IDX_HOT_TOL) begin
					wbDatR <= {16'h0000, hotTol};
				end else if (wordIdx >= `RTV_IDX_FULL_DT && wordIdx < `RTV_IDX_BIAS) begin
					wbDatR <= {16'h0000, fullDt[fullOff[1:0]]};
				end else if (wordIdx >= `RTV_IDX_BIAS && wordIdx < `RTV_IDX_DELTA) begin
					wbDatR <= {16'h0000, hotDetectorBias[biasOff[3:0]]};
				end else if (wordIdx >= `RTV_IDX_DELTA && wordIdx < `RTV_IDX_AVG) begin
					wbDatR <= {16'h0000, deltaMem[wordIdx[1:0]]};
				end else if (wordIdx >= `RTV_IDX_AVG && wordIdx < `RTV_IDX_QUAL) begin
					wbDatR <= {16'h0000, avgMem[wordIdx[1:0]]};
				end else if (wordIdx >= `RTV_IDX_QUAL && wordIdx < `RTV_IDX_END) begin
					wbDatR <= {21'h000000, qualMem[wordIdx[1:0]]};
				end
			end
		end
	end

endmodule // redundant_temp_voting
`default_nettype wire

// ==== core/redundant_temp_voting_regs.vh ====
// Constants for the redundant coolant temperature voting block.
// Assumes a Wishbone slave with 8-bit byte addresses and 32-bit words.
`ifndef REDUNDANT_TEMP_VOTING_REGS_VH
`define REDUNDANT_TEMP_VOTING_REGS_VH

// Word indices of the registers; the byte address is four times the index.
`define RTV_IDX_CTRL 6'h00
`define RTV_IDX_STATUS 6'h01
`define RTV_IDX_COLD_TOL 6'h02
`define RTV_IDX_HOT_TOL 6'h03
`define RTV_IDX_FULL_DT 6'h04
`define RTV_IDX_BIAS 6'h08
`define RTV_IDX_DELTA 6'h14
`define RTV_IDX_AVG 6'h18
`define RTV_IDX_QUAL 6'h1C
`define RTV_IDX_END 6'h20

// Quality codes of a voted group.
`define RTV_Q_GOOD 2'h0
`define RTV_Q_POOR 2'h1
`define RTV_Q_BAD 2'h2

// Fixed-point layout: signed, fraction bits below the binary point.
`define RTV_FRAC_BITS 8
`define RTV_ONE 16'h0100

// Reset values of the agreement tolerances (2.0 degrees) and full-power delta (32.0).
`define RTV_COLD_TOL_RST 16'h0200
`define RTV_HOT_TOL_RST 16'h0200
`define RTV_FULL_DT_RST 16'h2000

// Field positions inside a loop quality word.
`define RTV_QF_COLD 1:0
`define RTV_QF_HOT 3:2
`define RTV_QF_POOR 8:4
`define RTV_QF_LOOP_STATUS_A 9
`define RTV_QF_FAIL 10

`endif

// ==== tb/redundant_temp_voting_properties.sv ====
// Port-level checks on the four-loop temperature voting block.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module rtv_port_checker #(
	parameter W = 16
) (
	// Clock and reset.
	input wire clock,
	input wire rst,
	// Register bus.
	input wire wbCyc,
	input wire wbStb,
	input wire wbWe,
	input wire [7:0] wbAdr,
	input wire [3:0] wbSel,
	input wire [31:0] wbDatW,
	input wire [31:0] wbDatR,
	input wire wbAck,
	// Sampling and results.
	input wire sampleStrobe,
	input wire [4*W-1:0] loopDelta,
	input wire [3:0] loopStatusA,
	input wire [3:0] sensorFailureStatus,
	input wire resultValid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// A pass starts on a strobe or on a taken write of the start bit in the control word.
	wire passGo = sampleStrobe | (wbCyc & wbStb & ~wbAck & wbWe & (wbAdr[7:2] == 6'h00)
		& wbSel[0] & wbDatW[0]);

	AST_ACK_NEXT: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("Bus request was not acknowledged in the next cycle.");
	AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
		else $error("Acknowledge stood longer than one cycle.");
	AST_ACK_CAUSE: assert property (wbAck |-> $past(wbCyc && wbStb))
		else $error("Acknowledge came without a request.");
	AST_DATR_IDLE: assert property (!wbAck |-> wbDatR == 32'h0)
		else $error("Read data not zero outside acknowledge.");
	AST_VALID_PULSE: assert property (resultValid |=> !resultValid)
		else $error("Result valid stood longer than one cycle.");
	AST_VALID_CAUSE: assert property (resultValid |-> ($past(passGo, 4)
		|| $past(passGo, 5) || $past(passGo, 6)))
		else $error("Result valid without a start four to six cycles before.");
	AST_DELTA_HOLD: assert property ((!passGo) [*7] |=> $stable(loopDelta))
		else $error("Loop delta changed with no pass running.");
	AST_STATUS_HOLD: assert property ((!passGo) [*7] |=> $stable(loopStatusA))
		else $error("Loop_status_a status changed with no pass running.");
	AST_FAIL_LOOP_STATUS_A: assert property ((sensorFailureStatus & ~loopStatusA) == 4'h0)
		else $error("Sensor failure raised without loop_status_a.");
endmodule // rtv_port_checker

bind redundant_temp_voting rtv_port_checker #(.W(W)) rtv_port_checker_inst (
	.clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
	.wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
	.sampleStrobe(sampleStrobe), .loopDelta(loopDelta), .loopStatusA(loopStatusA),
	.sensorFailureStatus(sensorFailureStatus), .resultValid(resultValid));
`default_nettype wire

// ==== tb/redundant_temp_voting_test.sv ====
// Self-checking bench for the four-loop temperature voting block.
// Assumes the block, its register header, checker and channel model are compiled first.
`default_nettype none
module redundant_temp_voting_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, sampleStrobe = 0, setEn = 0;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDatW = 32'h0, wbDatR, rd;
	logic wbAck, resultValid;
	logic [4:0] setSlot = 5'h00;
	logic [15:0] setVal = 16'h0000;
	logic [2:0] setFlags = 3'h0;
	logic [319:0] readings;
	logic [19:0] inputBad, inputFlagB, inputLowScale;
	logic [63:0] loopDelta, loopAverage;
	logic [3:0] loopStatusA, sensorFailureStatus;
	int fail_count = 0, checks_done = 0;
	logic [15:0] vals [20] = '{16'h2000, 16'h2100, 16'h3000, 16'h3100, 16'h3200,
		16'h0000, 16'h2000, 16'h3000, 16'h3000, 16'h3900,
		16'h1C00, 16'h2000, 16'h3000, 16'h3000, 16'h3400,
		16'h2000, 16'h0000, 16'h3000, 16'h3100, 16'h3200};

	// Free-running clock.
	always #10 clock = ~clock;

	redundant_temp_voting #(.W(16)) redundant_temp_voting_inst (.clock(clock), .rst(rst),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .sampleStrobe(sampleStrobe),
		.readings(readings), .inputBad(inputBad), .inputFlagB(inputFlagB),
		.inputLowScale(inputLowScale), .loopDelta(loopDelta), .loopAverage(loopAverage),
		.loopStatusA(loopStatusA), .sensorFailureStatus(sensorFailureStatus),
		.resultValid(resultValid));
	rtd_channel_model #(.W(16)) rtd_channel_model_inst (.clock(clock), .setEn(setEn),
		.setSlot(setSlot), .setVal(setVal), .setFlags(setFlags), .readings(readings),
		.inputBad(inputBad), .inputFlagB(inputFlagB), .inputLowScale(inputLowScale));

	// Prints the verdict and ends the run.
	task automatic give_verdict();
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Compares one value and reports a difference.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask

	// One classic bus cycle; the request holds until acknowledge is sampled high.
	task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock);
		wbCyc <= 1;
		wbStb <= 1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= 4'h3;
		wbDatW <= {16'h0000, d};
		do begin
			@(posedge clock);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		r = wbDatR;
		wbCyc <= 0;
		wbStb <= 0;
		wbWe <= 0;
		if (n >= 50) begin
			fail_count++;
			give_verdict();
		end
	endtask

	// Loads every channel slot, then starts one pass and waits for its results.
	task automatic run_pass(input logic [19:0] bad, input logic [19:0] dis,
		input logic [19:0] low);
		for (int s = 0; s < 20; s++) begin
			@(posedge clock);
			setEn <= 1;
			setSlot <= s[4:0];
			setVal <= vals[s];
			setFlags <= {low[s], dis[s], bad[s]};
		end
		@(posedge clock);
		setEn <= 0;
		sampleStrobe <= 1;
		@(posedge clock);
		sampleStrobe <= 0;
		wait_valid();
	endtask

	// Waits a bounded number of cycles for the end-of-pass pulse.
	task automatic wait_valid();
		int n;
		n = 0;
		while (resultValid !== 1'b1 && n < 20) begin
			@(posedge clock);
			n++;
		end
		if (n >= 20) begin
			fail_count++;
			give_verdict();
		end
	endtask

	// Checks one loop's outputs and the masked fields of its quality word.
	task automatic loop_chk(input int i, input logic [15:0] d, input logic [15:0] a,
		input logic [1:0] st, input logic [10:0] q, input logic [10:0] m);
		logic [31:0] r;
		chk({16'h0, loopDelta[i*16 +: 16]}, {16'h0, d});
		chk({16'h0, loopAverage[i*16 +: 16]}, {16'h0, a});
		chk({30'h0, sensorFailureStatus[i], loopStatusA[i]}, {30'h0, st});
		wb(0, 8'h70 + 8'(i * 4), 16'h0, r);
		chk(r & {21'h0, m}, {21'h0, q});
	endtask

	// Main sequence: defaults, refused accesses, three passes, the last two with bias correction.
	initial begin
		repeat (20) @(posedge clock);
		rst <= 0;
		wb(0, 8'h08, 16'h0, rd);
		chk(rd, 32'h0200);
		wb(0, 8'h0C, 16'h0, rd);
		chk(rd, 32'h0200);
		wb(0, 8'h10, 16'h0, rd);
		chk(rd, 32'h2000);
		wb(1, 8'h50, 16'h1234, rd);
		wb(0, 8'h50, 16'h0, rd);
		chk(rd, 32'h0);
		wb(0, 8'h80, 16'h0, rd);
		chk(rd, 32'h0);
		run_pass(20'hE9020, 20'h10000, 20'hF8000);
		loop_chk(0, 16'h1080, 16'h28C0, 2'b00, 11'h000, 11'h7FF);
		loop_chk(1, 16'h1000, 16'h2800, 2'b01, 11'h305, 11'h7CF);
		loop_chk(2, 16'h1400, 16'h2800, 2'b11, 11'h7BA, 11'h7FF);
		loop_chk(3, 16'h1100, 16'h2880, 2'b00, 11'h00A, 11'h60F);
		wb(0, 8'h04, 16'h0, rd);
		chk(rd, 32'h0460);
		for (int j = 0; j < 3; j++) begin
			wb(1, 8'h20 + 8'(4 * j), 16'h0100, rd);
		end
		wb(0, 8'h28, 16'h0, rd);
		chk(rd, 32'h0100);
		run_pass(20'hC9020, 20'h10000, 20'hF0000);
		loop_chk(0, 16'h0FFC, 16'h287E, 2'b00, 11'h000, 11'h7FF);
		loop_chk(1, 16'h1000, 16'h2800, 2'b01, 11'h305, 11'h7CF);
		loop_chk(2, 16'h1400, 16'h2800, 2'b11, 11'h7BA, 11'h7FF);
		loop_chk(3, 16'h1000, 16'h2800, 2'b11, 11'h60A, 11'h60F);
		wb(1, 8'h00, 16'h0001, rd);
		wait_valid();
		loop_chk(0, 16'h1001, 16'h2880, 2'b00, 11'h000, 11'h7FF);
		give_verdict();
	end
endmodule // redundant_temp_voting_test
`default_nettype wire

// ==== tb/rtd_channel_model.sv ====
// Model of the filtered temperature detector channels feeding the voting block.
// Assumes the bench loads one slot a clock and never during an evaluation pass.
`default_nettype none
module rtd_channel_model #(
	parameter W = 16
) (
	// Clock.
	input wire logic clock,
	// Slot load port from the bench.
	input wire logic setEn,
	input wire logic [4:0] setSlot,
	input wire logic [W-1:0] setVal,
	input wire logic [2:0] setFlags,
	// Channel outputs.
	output logic [20*W-1:0] readings,
	output logic [19:0] inputBad,
	output logic [19:0] inputFlagB,
	output logic [19:0] inputLowScale
);
	timeunit 1ns;
	timeprecision 1ns;
	// All channels start at zero and good so the block never sees unknowns.
	initial begin
		readings = '0;
		inputBad = '0;
		inputFlagB = '0;
		inputLowScale = '0;
	end
	// A slot keeps its reading and flags until reloaded, so they hold through a pass.
	always @(posedge clock) begin
		if (setEn) begin
			readings[setSlot*W +: W] <= setVal;
			inputBad[setSlot] <= setFlags[0];
			inputFlagB[setSlot] <= setFlags[1];
			inputLowScale[setSlot] <= setFlags[2];
		end
	end
endmodule // rtd_channel_model
`default_nettype wire
